// file: design/bbse_pkg.sv
/*
  package: opcode groups, instruction lengths, cycle counts and widths for the bit-test,
  bit-set, branch-never and branch-to-subroutine execution unit.
  assumes: included by every design file of the unit; no clock or reset of its own.
*/
package bbse_pkg;
  localparam int          ADDR_W          = 16;       // address width
  localparam int          DATA_W          = 8;        // data width
  // opcode groups: upper nibble selects the group, low bit selects set or clear test in the bit branch group
  localparam logic [3:0]  GRP_BIT_BRANCH  = 4'h0;     // 0x00..0x0f
  localparam logic [3:0]  GRP_BIT_SET     = 4'h1;     // 0x10..0x1e, even only
  localparam logic [7:0]  OP_BRANCH_NEVER = 8'h21;    // two bytes
  localparam logic [7:0]  OP_BRANCH_SUB   = 8'had;    // two bytes
  // instruction lengths, used as the step from the opcode address
  localparam logic [15:0] LEN_DIR_REL     = 16'h0003; // opcode, address, offset
  localparam logic [15:0] LEN_TWO         = 16'h0002; // opcode plus one byte
  localparam logic [15:0] ONE16           = 16'h0001; // byte step
  localparam logic [7:0]  DIRECT_PAGE_HI  = 8'h00;    // upper byte of a direct address
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
  localparam logic [15:0] WORD_ZERO       = 16'h0000;
  // cycle budget of each instruction, opcode cycle included
  localparam int          CYC_BIT_BRANCH  = 5;
  localparam int          CYC_BIT_SET     = 4;
  localparam int          CYC_BRANCH_NEV  = 3;
  localparam int          CYC_BRANCH_SUB  = 4;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE      = 5'h01,
    ST_FETCH_DIR = 5'h02,
    ST_FETCH_OFS = 5'h04,
    ST_READ_MEM  = 5'h08,
    ST_PUSH_LO   = 5'h10
  } bbse_state_t;
  // instruction class picked at decode
  typedef enum logic [2:0] {
    CL_NONE       = 3'h0,
    CL_BIT_BRANCH = 3'h1,
    CL_BIT_SET    = 3'h2,
    CL_BRANCH_NEV = 3'h3,
    CL_BRANCH_SUB = 3'h4
  } bbse_class_t;
endpackage

// file: design/bbse_target_if.sv
/*
  interface: carries the branch target request from the sequencer to the target adder.
  assumes: purely combinational, no clock; the sequencer drives, the adder answers.
*/
`timescale 1ns/1ps
interface bbse_target_if;
  import bbse_pkg::*;
  logic [15:0] base;   // opcode address
  logic [15:0] step;   // instruction length
  logic [7:0]  offset; // signed displacement byte
  logic        take;   // add the displacement
  logic [15:0] target; // resulting program counter
  modport seq (output base, output step, output offset, output take, input target);
  modport calc (input base, input step, input offset, input take, output target);
endinterface

// file: design/bbse_target_calc.sv
/*
  module: branch target adder, opcode address plus length plus optional displacement.
  assumes: combinational; base and step come from registers of the sequencer, while offset and take follow the memory read data.
*/
`timescale 1ns/1ps
module bbse_target_calc
  import bbse_pkg::*;
(
  // target request and answer
  bbse_target_if.calc tgt
);
  // displacement widened with its sign bit, or zero when not taken
  wire [15:0] ext_ofs  = tgt.take ? {{8{tgt.offset[7]}}, tgt.offset} : WORD_ZERO; // see [RL14]
  // plain 16-bit sums drop the carry, so the target wraps silently
  wire [15:0] next_seq = tgt.base + tgt.step;                               // see [RL13]
  assign tgt.target = next_seq + ext_ofs;                                   // see [RL15]
endmodule

// file: design/bbse_exec.sv
/*
  module: execution sequencer for bit test and branch, bit set, branch never and
  branch to subroutine; it fetches operand bytes, drives stack writes and hands
  back the new program counter, stack pointer and carry.
  assumes: the core has fetched the opcode and pulses start in the opcode cycle;
  memory answers a read in the same cycle the read strobe stands; writes finish
  in the cycle they are issued.
*/
// How it works
// [RL1] branch-if-bit-clear jumps to opcode+3+offset when zero
// [RL2] branch-if-bit-set jumps when one, else falls through
// [RL3] direct operand address has upper byte zero
// [RL4] bit tests copy tested bit into carry only
// [RL5] odd opcodes 0x01..0x0f: clear test, 5 cycles
// [RL6] even opcodes 0x00..0x0e: set test, 5 cycles
// [RL7] bit set reads, forces one bit, writes back
// [RL8] opcodes 0x10..0x1e set bit, 4 cycles
// [RL9] branch-never 0x21: pc plus 2, 3 cycles
// [RL10] subroutine return address is opcode address plus 2
// [RL11] push low at sp, dec, high, dec
// [RL12] 0xad: pc = return address plus offset
// [RL13] displacement is last instruction byte, two's complement
// [RL14] taken branch sign-extends displacement to 16 bits
// [RL15] program counter sums wrap modulo 65536
// [RL16] memory answers reads and takes writes in time
`timescale 1ns/1ps
module bbse_exec
  import bbse_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // instruction hand-off from the core
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [15:0] opcode_addr,
  input  wire logic [15:0] stack_pointer_in,
  // completion back to the core
  output logic             busy,
  output logic             done,
  output logic             unsupported,
  output logic [15:0]      program_counter,
  output logic [15:0]      stack_pointer,
  output logic             carry_we,
  output logic             carry,
  // memory and i/o bus
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata
);

  bbse_state_t state;        // sequencer state
  bbse_class_t op_class;     // class latched at start
  logic [2:0]  bit_sel;      // selected bit number
  logic        want_set;     // bit test branches on one
  logic [15:0] op_addr;      // opcode address of the running instruction
  logic [7:0]  dir_addr;     // direct-page address byte
  logic [7:0]  rel_ofs;      // displacement byte

  // decode of the incoming opcode
  wire        grp_bb   = opcode[7:4] == GRP_BIT_BRANCH;               // see [RL5] [RL6]
  wire        grp_bs   = (opcode[7:4] == GRP_BIT_SET) && !opcode[0];  // see [RL8]
  wire        is_nev   = opcode == OP_BRANCH_NEVER;                   // see [RL9]
  wire        is_sub   = opcode == OP_BRANCH_SUB;                     // see [RL12]
  wire        known    = grp_bb | grp_bs | is_nev | is_sub;
  wire [2:0]  in_bit   = opcode[3:1];                                 // bit n from 2n or 2n+1
  wire        in_set   = !opcode[0];                                  // even code tests for one
  // direct page address: upper byte forced to zero
  wire [15:0] dir_word = {DIRECT_PAGE_HI, dir_addr};                  // see [RL3]
  // tested bit of the operand byte read this cycle
  wire        mem_bit  = mem_rdata[bit_sel];
  wire        taken    = (mem_bit == want_set);                      // see [RL1] [RL2]
  // byte with only the selected bit forced high
  wire [7:0]  set_mask = 8'h01 << bit_sel;
  wire [7:0]  set_byte = mem_rdata | set_mask;                        // see [RL7]
  // return address and stack steps
  wire [15:0] ret_addr = op_addr + LEN_TWO;                           // see [RL10]
  wire [15:0] sp_dec1  = stack_pointer_in - ONE16;
  wire [15:0] sp_dec2  = sp_dec1 - ONE16;
  wire [15:0] op_next2 = op_addr + LEN_TWO;

  // target adder request; the displacement is only honoured when it applies
  bbse_target_if tgt ();
  wire        take_ofs = (op_class == CL_BRANCH_SUB) ||
                         ((op_class == CL_BIT_BRANCH) && taken);      // see [RL14]
  assign tgt.base   = op_addr;
  assign tgt.step   = (op_class == CL_BIT_BRANCH) ? LEN_DIR_REL : LEN_TWO;
  assign tgt.offset = (state == ST_FETCH_OFS) ? mem_rdata : rel_ofs;  // see [RL13]
  assign tgt.take   = take_ofs;

  bbse_target_calc u_calc (
    .tgt (tgt.calc)
  );

  // instruction context, captured once per instruction
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_class <= CL_NONE;
      bit_sel  <= 3'h0;
      want_set <= 1'b0;
      op_addr  <= WORD_ZERO;
    end else if (start && !busy) begin
      op_class <= grp_bb ? CL_BIT_BRANCH :
                  grp_bs ? CL_BIT_SET    :
                  is_nev ? CL_BRANCH_NEV :
                  is_sub ? CL_BRANCH_SUB : CL_NONE;
      bit_sel  <= in_bit;
      want_set <= in_set;
      op_addr  <= opcode_addr;
    end
  end

  // operand bytes, caught in the cycle the memory answers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_addr <= BYTE_ZERO;
      rel_ofs  <= BYTE_ZERO;
    end else begin
      if (state == ST_FETCH_DIR) begin
        dir_addr <= mem_rdata;
      end
      if (state == ST_FETCH_OFS) begin
        rel_ofs <= mem_rdata;                                         // see [RL13]
      end
    end
  end

  // sequencer: every output is a flop, set one edge ahead of the cycle it shows in
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state           <= ST_IDLE;
      busy            <= 1'b0;
      done            <= 1'b0;
      unsupported     <= 1'b0;
      program_counter <= WORD_ZERO;
      stack_pointer   <= WORD_ZERO;
      carry_we        <= 1'b0;
      carry           <= 1'b0;
      mem_addr        <= WORD_ZERO;
      mem_rd          <= 1'b0;
      mem_wr          <= 1'b0;
      mem_wdata       <= BYTE_ZERO;
    end else begin
      // pulses default low each cycle
      done        <= 1'b0;
      unsupported <= 1'b0;
      carry_we    <= 1'b0;
      mem_rd      <= 1'b0;
      mem_wr      <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start && known) begin
            // every supported opcode fetches the byte after the opcode next
            busy     <= 1'b1;
            mem_addr <= opcode_addr + ONE16;
            mem_rd   <= 1'b1;
            state    <= (grp_bb || grp_bs) ? ST_FETCH_DIR : ST_FETCH_OFS;
          end else if (start) begin
            // unknown codes finish at once and leave the pc alone
            done            <= 1'b1;
            unsupported     <= 1'b1;
            program_counter <= opcode_addr;
            stack_pointer   <= stack_pointer_in;
          end
        end
        ST_FETCH_DIR: begin
          if (op_class == CL_BIT_SET) begin
            // bit set goes straight to the operand read
            mem_addr <= {DIRECT_PAGE_HI, mem_rdata};                  // see [RL3] [RL8]
            mem_rd   <= 1'b1;
            state    <= ST_READ_MEM;
          end else begin
            // bit test fetches its displacement first
            mem_addr <= op_next2;                                     // see [RL5] [RL6]
            mem_rd   <= 1'b1;
            state    <= ST_FETCH_OFS;
          end
        end
        ST_FETCH_OFS: begin
          case (op_class)
            CL_BIT_BRANCH: begin
              mem_addr <= dir_word;                                   // see [RL3]
              mem_rd   <= 1'b1;
              state    <= ST_READ_MEM;
            end
            CL_BRANCH_NEV: begin
              // offset byte is read and discarded; flags untouched
              done            <= 1'b1;
              busy            <= 1'b0;
              program_counter <= op_next2;                            // see [RL9]
              stack_pointer   <= stack_pointer_in;
              state           <= ST_IDLE;
            end
            CL_BRANCH_SUB: begin
              // low half of the return address goes first
              mem_addr  <= stack_pointer_in;                          // see [RL11]
              mem_wdata <= ret_addr[7:0];                             // see [RL10]
              mem_wr    <= 1'b1;
              state     <= ST_PUSH_LO;
            end
            default: begin
              busy  <= 1'b0;
              state <= ST_IDLE;
            end
          endcase
        end
        ST_READ_MEM: begin
          if (op_class == CL_BIT_SET) begin
            // write the whole byte back; flags are not touched
            mem_addr        <= dir_word;                              // see [RL7]
            mem_wdata       <= set_byte;                              // see [RL7]
            mem_wr          <= 1'b1;
            done            <= 1'b1;
            busy            <= 1'b0;
            program_counter <= op_next2;
            stack_pointer   <= stack_pointer_in;
          end else begin
            // only carry changes; it mirrors the tested bit either way
            carry           <= mem_bit;                               // see [RL4]
            carry_we        <= 1'b1;                                  // see [RL4]
            done            <= 1'b1;
            busy            <= 1'b0;
            program_counter <= tgt.target;                            // see [RL1] [RL2]
            stack_pointer   <= stack_pointer_in;
          end
          state <= ST_IDLE;
        end
        ST_PUSH_LO: begin
          // second push lands one below, and the pointer ends two below
          mem_addr        <= sp_dec1;                                 // see [RL11]
          mem_wdata       <= ret_addr[15:8];
          mem_wr          <= 1'b1;
          stack_pointer   <= sp_dec2;                                 // see [RL11]
          program_counter <= tgt.target;                              // see [RL12]
          done            <= 1'b1;
          busy            <= 1'b0;
          state           <= ST_IDLE;
        end
        default: begin
          busy  <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // limitation: start is ignored while busy, so the core holds its next opcode
  // until done; the done cycle itself may already carry the next start

endmodule

// file: testbench/bbse_exec_props.sv
/*
  checker: timing and data relations of the bit-test, bit-set, branch-never and
  subroutine sequencer, seen at its ports only.
  assumes: bound onto bbse_exec; one clock, reset active low.
*/
`timescale 1ns/1ps
module bbse_exec_props
  import bbse_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // hand-off and completion
  input wire logic        start,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [7:0]  opcode,
  input wire logic [15:0] opcode_addr,
  input wire logic [15:0] stack_pointer_in,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] stack_pointer,
  input wire logic        carry_we,
  input wire logic        carry,
  // memory bus
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [7:0]  mem_rdata
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [7:0]  op_q;  // opcode of the running instruction
  logic [15:0] a_q;   // its opcode address
  logic [7:0]  rd_q;  // last byte read
  wire         take = start && !busy;
  wire [15:0]  ret   = a_q + LEN_TWO;
  // capture context; a new start lands only after the done edge is sampled
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      op_q <= BYTE_ZERO;
      a_q  <= WORD_ZERO;
      rd_q <= BYTE_ZERO;
    end else begin
      if (take) begin
        op_q <= opcode;
        a_q  <= opcode_addr;
      end
      if (mem_rd) begin
        rd_q <= mem_rdata;
      end
    end
  end
  property p_bt_len;
    take && opcode[7:4] == 4'h0 |-> ##1 !done [*3] ##1 (done && carry_we);
  endproperty
  a_bt_len: assert property (p_bt_len) else $error("bit test length wrong");
  property p_bs_len;
    take && opcode[7:4] == 4'h1 && !opcode[0] |-> ##3 (done && mem_wr);
  endproperty
  a_bs_len: assert property (p_bs_len) else $error("bit set length wrong");
  property p_bn;
    take && opcode == 8'h21 |-> ##2 (done && program_counter == ret && !mem_wr);
  endproperty
  a_bn: assert property (p_bn) else $error("branch never wrong");
  property p_dp;
    take && opcode[7:4] == 4'h0 |-> ##3 (mem_rd && mem_addr[15:8] == 8'h00);
  endproperty
  a_dp: assert property (p_dp) else $error("direct address high byte set");
  property p_carry;
    carry_we |-> done && carry == rd_q[op_q[3:1]];
  endproperty
  a_carry: assert property (p_carry) else $error("carry not tested bit");
  property p_bs_data;
    mem_wr && op_q[7:4] == 4'h1 |-> mem_wdata == (rd_q | (8'h01 << op_q[3:1]));
  endproperty
  a_bs_data: assert property (p_bs_data) else $error("bit set data wrong");
  property p_push;
    take && opcode == 8'had |-> ##2 (mem_wr && mem_addr == stack_pointer_in
      && mem_wdata == ret[7:0]) ##1 (mem_wr && mem_wdata == ret[15:8]
      && mem_addr == stack_pointer_in - ONE16);
  endproperty
  a_push: assert property (p_push) else $error("return pushes wrong");
  property p_sp;
    take && opcode == 8'had |-> ##3 (done
      && stack_pointer == $past(stack_pointer_in, 3) - LEN_TWO);
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer not lowered by two");
  c_bt: cover property (carry_we && carry);
  c_bs: cover property (mem_wr && op_q[7:4] == 4'h1);
  c_bsr: cover property (mem_wr ##1 (mem_wr && done));
endmodule
bind bbse_exec bbse_exec_props u_props (.ref_clk, .rst_b, .start, .busy, .done, .opcode,
  .opcode_addr, .stack_pointer_in, .program_counter, .stack_pointer, .carry_we, .carry,
  .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

// file: testbench/bbse_mem_model.sv
/*
  partner: byte memory behind the sequencer's bus.
  assumes: reads answered in the strobe cycle, writes taken at the strobe's edge.
*/
`timescale 1ns/1ps
module bbse_mem_model (
  // clock
  input  wire logic        ref_clk,
  // bus from the sequencer
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [0:65535]; // whole address space, loaded by the bench
  logic [7:0] junk = 8'h5a;  // idle pattern so a late sample never looks valid
  // read data only while strobed, answered at once
  assign mem_rdata = mem_rd ? mem[mem_addr] : junk;
  // writes complete in their own cycle
  always @(posedge ref_clk) begin
    junk <= ~junk;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule

// file: testbench/test_bit_branch_subroutine_exec.sv
/*
  testbench: drives each instruction kind and checks counts, targets and memory.
  assumes: bbse_exec with its bound checker and bbse_mem_model as memory.
*/
`timescale 1ns/1ps
module test_bit_branch_subroutine_exec;
  import bbse_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, start = 1'b0;
  logic [7:0]  opcode = 8'h00;
  logic [15:0] opcode_addr = 16'h0000, stack_pointer_in = 16'h00ff;
  logic        busy, done, unsupported, carry_we, carry, mem_rd, mem_wr;
  logic [15:0] program_counter, stack_pointer, mem_addr;
  logic [7:0]  mem_wdata, mem_rdata;
  int          mismatches = 0, check_count = 0;
  bbse_exec u_dut (.ref_clk, .rst_b, .start, .opcode, .opcode_addr, .stack_pointer_in,
    .busy, .done, .unsupported, .program_counter, .stack_pointer, .carry_we, .carry,
    .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  bbse_mem_model u_mem (.ref_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  // 50 ns period
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one instruction from start to done; n is the cycle done was seen in
  task automatic run(input logic [7:0] op, input logic [15:0] a, output int n);
    start = 1'b1;
    opcode = op;
    opcode_addr = a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    start = 1'b0;
    n = 2;
    while (done !== 1'b1 && n < 12) begin
      @(negedge ref_clk);
      n++;
    end
    if (done !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
  endtask
  function automatic logic [15:0] sext(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction
  task automatic t_bit_branch();
    logic [15:0] a;
    logic [7:0] rr, m;
    logic b, tk;
    logic [15:0] exp_pc;
    int n;
    // all sixteen opcodes, both bit values, wrap past the top of memory
    for (int i = 0; i < 16; i++) begin
      a = 16'hffc0 + 16'(i * 8);
      rr = i[1] ? 8'h7f : 8'h80;
      m = i[2] ? (8'h01 << i[3:1]) : ~(8'h01 << i[3:1]);
      u_mem.mem[a + 16'h0001] = 8'h40 + 8'(i);
      u_mem.mem[a + 16'h0002] = rr;
      u_mem.mem[16'h0040 + 16'(i)] = m;
      b = m[i[3:1]];
      tk = i[0] ? !b : b;
      run(8'(i), a, n);
      cmp("bit test cycles", 16'h0005, 16'(n));
      exp_pc = a + LEN_DIR_REL + (tk ? sext(rr) : WORD_ZERO);
      cmp("bit test pc", exp_pc, program_counter);
      cmp("carry", {15'h0000, b}, {15'h0000, carry});
      cmp("carry write", 16'h0001, {15'h0000, carry_we});
    end
    $display("test bit_branch done");
  endtask
  task automatic t_bit_set();
    int n;
    for (int i = 0; i < 8; i++) begin
      u_mem.mem[16'h0101 + 16'(i * 4)] = 8'h80 + 8'(i);
      u_mem.mem[16'h0080 + 16'(i)] = 8'ha5;
      run(8'h10 + 8'(i * 2), 16'h0100 + 16'(i * 4), n);
      cmp("bit set cycles", 16'h0004, 16'(n));
      @(posedge ref_clk);
      #1;
      cmp("set byte", 16'(8'ha5 | (8'h01 << i)), 16'(u_mem.mem[16'h80 + i]));
      cmp("bit set pc", 16'h0102 + 16'(i * 4), program_counter);
      @(negedge ref_clk);
    end
    $display("test bit_set done");
  endtask
  task automatic t_branch_never();
    int n;
    u_mem.mem[16'hffff] = 8'h40;
    run(8'h21, 16'hfffe, n);
    cmp("never cycles", 16'h0003, 16'(n));
    cmp("never pc", 16'h0000, program_counter);
    cmp("never busy", 16'h0000, {15'h0000, busy});
    $display("test branch_never done");
  endtask
  task automatic t_subroutine();
    int n;
    u_mem.mem[16'h0011] = 8'h80;
    u_mem.mem[16'h00fe] = 8'hee;
    stack_pointer_in = 16'h00ff;
    run(8'had, 16'h0010, n);
    cmp("sub cycles", 16'h0004, 16'(n));
    cmp("sub pc", 16'hff92, program_counter);
    cmp("sub sp", 16'h00fd, stack_pointer);
    @(posedge ref_clk);
    #1;
    cmp("ret low", 16'h0012, {8'h00, u_mem.mem[16'h00ff]});
    cmp("ret high", 16'h0000, {8'h00, u_mem.mem[16'h00fe]});
    @(negedge ref_clk);
    run(8'h11, 16'h0300, n);
    cmp("unknown cycles", 16'h0002, 16'(n));
    cmp("unknown flag", 16'h0001, {15'h0000, unsupported});
    cmp("unknown pc", 16'h0300, program_counter);
    $display("test subroutine done");
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    t_bit_branch();
    t_bit_set();
    t_branch_never();
    t_subroutine();
    give_verdict();
  end
endmodule
